// [design/gpx_port.sv]
`timescale 1ns/1ps
`include "gpx_defs.svh"

// Operation
// - bit 7 of 30h enables the port
// - direction bit one input, zero output
// - output pin data bit writable, readable, driven
// - input pin data bit read-only, returns pin
// - flip bit one inverts both directions
// - flip bit zero passes value unchanged
// - device 7 at index 07h selects GPIO
// - AAh at index port locks access
// - two 87h writes unlock access
// - index at 2Eh, data at 2Fh
module gpx_port #(
    parameter int PIN_COUNT = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // host i/o cycles
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    // gpio pins
    input wire logic [PIN_COUNT-1:0] gpio_in,
    output logic [PIN_COUNT-1:0] gpio_out,
    output logic [PIN_COUNT-1:0] gpio_oe
);
    import gpx_pkg::*;

    // registers are eight bits wide, so no more pins than that
    if (PIN_COUNT < 1 || PIN_COUNT > 8) begin : g_bad_count
        $error("PIN_COUNT must be 1 to 8");
    end

    gpx_lock_t state_reg, state_next; // unlock sequence state
    logic [7:0] index_reg, index_next; // selected register number
    logic [7:0] ldn_reg, ldn_next; // selected logical device
    logic [7:0] enable_reg, enable_next; // gpio_global_enable
    logic [7:0] direction_config_reg, dir_next; // gpio_direction
    logic [7:0] pin_value_reg, data_next; // gpio_pin_data
    logic [7:0] polarity_flip_reg, inv_next; // gpio_polarity_invert
    logic [7:0] rdata_next;
    logic [7:0] rd_bits; // per-pin data read view
    logic [7:0] rd_reg_value;

    // address decode
    wire is_index = (io_addr == `GPX_INDEX_PORT);
    wire is_data = (io_addr == `GPX_DATA_PORT);
    wire open = (state_reg == gpx_open);
    wire wr_index = io_wr && is_index;
    wire wr_data = io_wr && is_data && open;
    wire ldn_gpio = (ldn_reg == `GPX_LDN_GPIO);
    wire ldn_enbank = (ldn_reg == `GPX_LDN_ENBANK);
    wire sel_ldn = (index_reg == `GPX_REG_LDN);
    wire sel_enable = ldn_enbank && (index_reg == `GPX_REG_ENABLE);
    wire sel_dir = ldn_gpio && (index_reg == `GPX_REG_DIR);
    wire sel_data = ldn_gpio && (index_reg == `GPX_REG_DATA);
    wire sel_inv = ldn_gpio && (index_reg == `GPX_REG_INV);
    wire port_en = enable_reg[`GPX_ENABLE_BIT];

    // unlock needs two keys in a row at the index port; any other index port write in between falls back
    always_comb begin
        state_next = state_reg;
        if (wr_index) begin
            unique case (state_reg)
                gpx_locked: begin
                    if (io_wdata == `GPX_KEY_UNLOCK) state_next = gpx_key_half;
                end
                gpx_key_half: begin
                    // a stray value restarts the sequence
                    state_next = (io_wdata == `GPX_KEY_UNLOCK) ? gpx_open : gpx_locked;
                end
                gpx_open: begin
                    if (io_wdata == `GPX_KEY_LOCK) state_next = gpx_locked;
                end
            endcase
        end
    end

    // index captured only while open; the lock key is not stored
    assign index_next = (wr_index && open && io_wdata != `GPX_KEY_LOCK) ? io_wdata : index_reg;
    assign ldn_next = (wr_data && sel_ldn) ? io_wdata : ldn_reg;
    assign enable_next = (wr_data && sel_enable) ? io_wdata : enable_reg;
    assign dir_next = (wr_data && sel_dir) ? io_wdata : direction_config_reg;
    assign inv_next = (wr_data && sel_inv) ? io_wdata : polarity_flip_reg;
    // input bits keep their old value, only output bits take the write
    assign data_next = (wr_data && sel_data) ?
        ((io_wdata & ~direction_config_reg) | (pin_value_reg & direction_config_reg)) :
        pin_value_reg;

    // read mux; unselected offsets read as idle bus
    assign rd_reg_value = sel_ldn ? ldn_reg :
                          sel_enable ? enable_reg :
                          sel_dir ? direction_config_reg :
                          sel_data ? rd_bits :
                          sel_inv ? polarity_flip_reg : `GPX_IDLE_READ;
    assign rdata_next = !open ? `GPX_IDLE_READ :
                        is_index ? index_reg :
                        is_data ? rd_reg_value : `GPX_IDLE_READ;

    // configuration state
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= gpx_locked;
            index_reg <= `GPX_RST_INDEX;
            ldn_reg <= `GPX_RST_LDN;
            enable_reg <= `GPX_RST_ENABLE;
        end else begin
            state_reg <= state_next;
            index_reg <= index_next;
            ldn_reg <= ldn_next;
            enable_reg <= enable_next;
        end
    end

    // gpio bank registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            direction_config_reg <= `GPX_RST_DIR;
            pin_value_reg <= `GPX_RST_DATA;
            polarity_flip_reg <= `GPX_RST_INV;
        end else begin
            direction_config_reg <= dir_next;
            pin_value_reg <= data_next;
            polarity_flip_reg <= inv_next;
        end
    end

    // read answer, one cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            io_rdata <= `GPX_IDLE_READ;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= io_rd;
            if (io_rd) io_rdata <= rdata_next;
        end
    end

    // one cell per pin; bits above PIN_COUNT read back the latch
    for (genvar i = 0; i < 8; i++) begin : g_pin
        if (i < PIN_COUNT) begin : g_cell
            gpx_pin_cell u_cell (
                .clock(clock),
                .sys_rst(sys_rst),
                .port_en(port_en),
                .dir_in(direction_config_reg[i]),
                .inv_bit(polarity_flip_reg[i]),
                .data_bit(pin_value_reg[i]),
                .pin_async(gpio_in[i]),
                .pin_out_reg(gpio_out[i]),
                .pin_oe_reg(gpio_oe[i]),
                .rd_bit(rd_bits[i])
            );
        end else begin : g_none
            assign rd_bits[i] = pin_value_reg[i];
        end
    end

    // second key opens access
    property p_unlock;
        @(posedge clock) disable iff (sys_rst)
        (state_reg == gpx_locked && wr_index && io_wdata == `GPX_KEY_UNLOCK)
        ##1 (wr_index && io_wdata == `GPX_KEY_UNLOCK) |=> (state_reg == gpx_open);
    endproperty
    a_unlock: assert property (p_unlock) else $error("double key did not unlock");

    // single key alone never opens
    property p_no_single;
        @(posedge clock) disable iff (sys_rst)
        (state_reg == gpx_locked) |=> (state_reg != gpx_open);
    endproperty
    a_no_single: assert property (p_no_single) else $error("opened on one key");

    // lock key closes and ignores data writes
    property p_lock;
        @(posedge clock) disable iff (sys_rst)
        (open && wr_index && io_wdata == `GPX_KEY_LOCK) |=>
        (state_reg == gpx_locked) ##1 ($stable(ldn_reg) && $stable(direction_config_reg));
    endproperty
    a_lock: assert property (p_lock) else $error("lock key not honoured");

    // device select write lands in ldn
    property p_ldn;
        @(posedge clock) disable iff (sys_rst)
        (wr_data && sel_ldn) |=> (ldn_reg == $past(io_wdata));
    endproperty
    a_ldn: assert property (p_ldn) else $error("device select lost");

    // input bits untouched by data writes
    property p_input_ro;
        @(posedge clock) disable iff (sys_rst)
        (wr_data && sel_data) |=>
        (((pin_value_reg ^ $past(pin_value_reg)) & $past(direction_config_reg)) == 8'h00);
    endproperty
    a_input_ro: assert property (p_input_ro) else $error("input bit written");

    // disabled port drives nothing
    property p_enable;
        @(posedge clock) disable iff (sys_rst)
        !port_en |=> (gpio_oe == '0);
    endproperty
    a_enable: assert property (p_enable) else $error("pin driven while disabled");

    // locked reads see idle bus
    property p_locked_read;
        @(posedge clock) disable iff (sys_rst)
        (io_rd && !open) |=> (io_rvalid && io_rdata == `GPX_IDLE_READ);
    endproperty
    a_locked_read: assert property (p_locked_read) else $error("locked read leaked");

    // direction reads back at the data port
    property p_dir_read;
        @(posedge clock) disable iff (sys_rst)
        (io_rd && is_data && open && sel_dir) |=> (io_rdata == $past(direction_config_reg));
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction readback wrong");

endmodule : gpx_port

// [design/gpx_defs.svh]
`ifndef GPX_DEFS_SVH
`define GPX_DEFS_SVH

// host i/o port addresses
`define GPX_INDEX_PORT 16'h002E
`define GPX_DATA_PORT 16'h002F

// keys written to the index port
`define GPX_KEY_UNLOCK 8'h87
`define GPX_KEY_LOCK 8'hAA

// configuration register offsets
`define GPX_REG_LDN 8'h07
`define GPX_REG_ENABLE 8'h30
`define GPX_REG_DIR 8'hE0
`define GPX_REG_DATA 8'hE1
`define GPX_REG_INV 8'hE2

// logical device numbers
`define GPX_LDN_GPIO 8'h07
`define GPX_LDN_ENBANK 8'h09

// field positions
`define GPX_ENABLE_BIT 7

// reset values (all pins start as inputs, port disabled)
`define GPX_RST_LDN 8'h00
`define GPX_RST_ENABLE 8'h00
`define GPX_RST_DIR 8'hFF
`define GPX_RST_DATA 8'h00
`define GPX_RST_INV 8'h00
`define GPX_RST_INDEX 8'h00

// value returned when nothing answers
`define GPX_IDLE_READ 8'hFF

`endif

// [design/gpx_pkg.sv]
package gpx_pkg;

    // configuration access lock state
    typedef enum logic [1:0] {
        gpx_locked,
        gpx_key_half,
        gpx_open
    } gpx_lock_t;

endpackage : gpx_pkg

// [design/gpx_pin_cell.sv]
`timescale 1ns/1ps

module gpx_pin_cell (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // per-pin configuration
    input wire logic port_en,
    input wire logic dir_in,
    input wire logic inv_bit,
    input wire logic data_bit,
    // pin side
    input wire logic pin_async,
    output logic pin_out_reg,
    output logic pin_oe_reg,
    // value seen by a data register read
    output logic rd_bit
);

    logic pin_meta_reg; // first sync stage, read only by pin_sync_reg
    logic pin_sync_reg; // settled pin level
    logic pin_out_next;
    logic pin_oe_next;

    // polarity flip sits on both paths so software sees one logical sense
    assign pin_out_next = data_bit ^ inv_bit;
    assign pin_oe_next = port_en & ~dir_in;
    assign rd_bit = dir_in ? (pin_sync_reg ^ inv_bit) : data_bit;

    // two-stage synchroniser, pin is asynchronous to clock
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= pin_async;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // registered drive so pin outputs never glitch
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    // enabled output pin drives the next cycle
    property p_oe_dir;
        @(posedge clock) disable iff (sys_rst)
        (port_en && !dir_in) |=> pin_oe_reg;
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("output pin not driven");

    // pin level equals data xor flip
    property p_out_pol;
        @(posedge clock) disable iff (sys_rst)
        1'b1 |=> (pin_out_reg == ($past(data_bit) ^ $past(inv_bit)));
    endproperty
    a_out_pol: assert property (p_out_pol) else $error("pin polarity wrong");

    // input read returns synced pin, flipped when asked
    property p_in_read;
        @(posedge clock) disable iff (sys_rst)
        dir_in |-> (rd_bit == (pin_sync_reg ^ inv_bit));
    endproperty
    a_in_read: assert property (p_in_read) else $error("input read wrong");

endmodule : gpx_pin_cell

// [dv/gpx_host_model.sv]
`timescale 1ns/1ps
`include "gpx_defs.svh"

// host software: index/data i/o cycles, one strobe per cycle
module gpx_host_model (
    // clock
    input wire logic clock,
    // host i/o cycles
    output logic [15:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid
);
    // idle bus from time zero
    initial begin
        io_addr = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end

    // released lines show the inverse, so stale values never pass as good
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clock);
        io_wr <= 1'b0;
        io_addr <= ~a;
        io_wdata <= ~d;
    endtask : wr

    // answer taken one edge after the strobe edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(posedge clock);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clock);
        io_rd <= 1'b0;
        io_addr <= ~a;
        @(posedge clock);
        v = io_rvalid;
        d = io_rdata;
    endtask : rd

    // two keys in a row open configuration access
    task automatic unlock();
        wr(`GPX_INDEX_PORT, `GPX_KEY_UNLOCK);
        wr(`GPX_INDEX_PORT, `GPX_KEY_UNLOCK);
    endtask : unlock

    // leave configuration mode
    task automatic lock();
        wr(`GPX_INDEX_PORT, `GPX_KEY_LOCK);
    endtask : lock

    // index first, then data port
    task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
        wr(`GPX_INDEX_PORT, {8'h00, i});
        wr(`GPX_DATA_PORT, d);
    endtask : cfg_wr

    task automatic cfg_rd(input logic [7:0] i, output logic [7:0] d, output logic v);
        wr(`GPX_INDEX_PORT, {8'h00, i});
        rd(`GPX_DATA_PORT, d, v);
    endtask : cfg_rd

    // pick the logical device before touching its registers
    task automatic sel(input logic [7:0] dev);
        cfg_wr(`GPX_REG_LDN, dev);
    endtask : sel
endmodule : gpx_host_model

// [dv/tb_top.sv]
`timescale 1ns/1ps
`include "gpx_defs.svh"

module tb_top;
    localparam int LIMIT = 20000; // cycles, well above the run length
    logic clock = 1'b0; // 250 MHz
    logic sys_rst = 1'b1;
    logic [15:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic io_rvalid;
    logic [7:0] gpio_in = 8'h00;
    logic [7:0] gpio_out;
    logic [7:0] gpio_oe;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] lfsr = 32'hAA67;
    logic [7:0] d;
    logic v;
    logic [7:0] dir, inv, dat, pin, stored;

    always #2 clock = ~clock;

    gpx_host_model host (.clock(clock), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));

    gpx_port #(.PIN_COUNT(8)) dut (.clock(clock), .sys_rst(sys_rst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe));

    // lfsr step, taps 32 22 2 1
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    // inputs read the pin through the flip bit, outputs the stored bit
    function automatic logic [7:0] exp_read(input logic [7:0] dr, iv, st, pn);
        return (dr & (pn ^ iv)) | (~dr & st);
    endfunction : exp_read

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        // locked: idle value, pins undriven
        host.rd(`GPX_DATA_PORT, d, v);
        chk("locked_read", `GPX_IDLE_READ, d);
        chk("rvalid", 8'h01, {7'h00, v});
        chk("reset_oe", 8'h00, gpio_oe);
        // a broken key pair must keep access closed
        host.wr(`GPX_INDEX_PORT, `GPX_KEY_UNLOCK);
        host.wr(`GPX_INDEX_PORT, 8'h07);
        host.wr(`GPX_INDEX_PORT, `GPX_KEY_UNLOCK);
        host.rd(`GPX_DATA_PORT, d, v);
        chk("broken_key", `GPX_IDLE_READ, d);
        host.lock();
        host.unlock();
        host.sel(`GPX_LDN_ENBANK);
        host.cfg_wr(`GPX_REG_ENABLE, 8'h80);
        host.cfg_rd(`GPX_REG_ENABLE, d, v);
        chk("enable", 8'h80, d);
        host.sel(`GPX_LDN_GPIO);
        host.cfg_rd(`GPX_REG_DIR, d, v);
        chk("dir_reset", `GPX_RST_DIR, d);
        stored = `GPX_RST_DATA;
        // first four passes: all-in/all-out with flip off/on, then random
        for (int i = 0; i < 24; i++) begin
            repeat (8) lfsr = next_rand(lfsr);
            dir = (i < 4) ? {8{i[0]}} : lfsr[7:0];
            inv = (i < 4) ? {8{i[1]}} : lfsr[15:8];
            dat = lfsr[23:16];
            pin = lfsr[31:24];
            gpio_in <= pin;
            host.cfg_wr(`GPX_REG_DIR, dir);
            host.cfg_wr(`GPX_REG_INV, inv);
            host.cfg_wr(`GPX_REG_DATA, dat);
            stored = (stored & dir) | (dat & ~dir);
            host.cfg_rd(`GPX_REG_DATA, d, v);
            chk("data_read", exp_read(dir, inv, stored, pin), d);
            chk("oe", ~dir, gpio_oe);
            // input pins still carry data xor flip on their undriven output flop
            chk("out", stored ^ inv, gpio_out);
        end
        // clearing the enable releases every pin one edge later
        host.sel(`GPX_LDN_ENBANK);
        host.cfg_wr(`GPX_REG_ENABLE, 8'h00);
        repeat (3) @(posedge clock);
        chk("oe_off", 8'h00, gpio_oe);
        host.cfg_rd(`GPX_REG_DIR, d, v);
        chk("wrong_dev", `GPX_IDLE_READ, d);
        host.lock();
        host.rd(`GPX_DATA_PORT, d, v);
        chk("relocked", `GPX_IDLE_READ, d);
        // mid-run reset: pins released, registers back to reset values
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        chk("rst_oe", 8'h00, gpio_oe);
        chk("rst_out", `GPX_RST_DATA ^ `GPX_RST_INV, gpio_out);
        host.rd(`GPX_DATA_PORT, d, v);
        chk("rst_locked", `GPX_IDLE_READ, d);
        chk("rst_rvalid", 8'h01, {7'h00, v});
        host.unlock();
        host.rd(`GPX_INDEX_PORT, d, v);
        chk("rst_index", `GPX_RST_INDEX, d);
        host.sel(`GPX_LDN_GPIO);
        host.cfg_rd(`GPX_REG_DIR, d, v);
        chk("rst_dir", `GPX_RST_DIR, d);
        host.cfg_rd(`GPX_REG_INV, d, v);
        chk("rst_inv", `GPX_RST_INV, d);
        // index port reads back the selected register while open
        host.rd(`GPX_INDEX_PORT, d, v);
        chk("index_read", `GPX_REG_INV, d);
        // lock and unlock keys leave the stored index alone
        host.lock();
        host.unlock();
        host.rd(`GPX_INDEX_PORT, d, v);
        chk("index_kept", `GPX_REG_INV, d);
        // an offset nobody decodes reads as idle bus
        host.cfg_rd(8'h55, d, v);
        chk("unknown_index", `GPX_IDLE_READ, d);
        report_and_stop();
    end
endmodule : tb_top
